// [pfm_defines.vh]
// constants for the port 9 / CM / CT pin function multiplexer
// What this block does
// - pin 9.2: timer4 ch1 capture/out, serial a4 transmit
// - pin 9.3: timer4 ch0 capture/out, serial a4 receive
// - pin 9.4: timer3 ch1 capture/out, serial a5 transmit
// - pin 9.5: timer3 ch0 capture/out, serial a5 receive
// - pin 9.6: serial c0 transmit, timer2 ch1 capture/out
// - pin 9.7: shared b1/c0 input, timer2 ch0
// - pins 9.8/9.9: clocked serial b1 out/clock
// - pins 9.10-9.13: b3 in/out/clock, interrupt 4
// - pin 9.14: interrupt 5, timer5 ch1 capture/out
// - pin 9.15: interrupt 6, timer5 ch0 capture/out
// - port CM: wait, clock out, hold ack/request
// - port CT: write strobes, read, address strobe
// - alternate mode drive ignores latch and direction bits
// - alternate-mode bit picks port or peripheral
// - data read: latch or pin by direction
`ifndef PFM_DEFINES_VH
`define PFM_DEFINES_VH

// register byte offsets
`define PFM_P9_DATA 12'h000
`define PFM_P9_DIR 12'h004
`define PFM_P9_ALT 12'h008
`define PFM_P9_FSL 12'h00c
`define PFM_P9_FSH 12'h010
`define PFM_CM_DATA 12'h020
`define PFM_CM_DIR 12'h024
`define PFM_CM_ALT 12'h028
`define PFM_CT_DATA 12'h030
`define PFM_CT_DIR 12'h034
`define PFM_CT_ALT 12'h038

// reset values: latch low, all pins input, port mode, code 0
`define PFM_RST_LAT16 16'h0000
`define PFM_RST_DIR16 16'hffff
`define PFM_RST_ALT16 16'h0000
`define PFM_RST_FS16 16'h0000
`define PFM_RST_DIR8 8'hff
`define PFM_RST_LAT4 4'h0
`define PFM_RST_DIR4 4'hf
`define PFM_RST_ALT4 4'h0
`define PFM_RST_LAT8 8'h00
`define PFM_RST_ALT8 8'h00

// bits 8..13 have no high select bit
`define PFM_P9_FSH_MASK 16'hc0ff

// select codes {high, low}
`define PFM_SEL_LO 2'b01
`define PFM_SEL_HI 2'b10
`define PFM_SEL_BOTH 2'b11

// peripheral input bundle: width and idle levels
`define PFM_IN_W 20
`define PFM_IN_IDLE 20'h01f24

`endif

// [pfm_in_stage.v]
// registered peripheral inputs with idle levels
`timescale 1ns/1ns
module pfm_in_stage #(
  parameter N = 20,
  parameter [N-1:0] IDLE = {N{1'b0}}
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // routing
  input wire [N-1:0] sel_i,
  input wire [N-1:0] raw_i,
  // to peripherals
  output reg [N-1:0] q_o
);
  // an unrouted input rests at idle so no false edge reaches a unit
  always @(posedge clk_i)
  begin
    if (rst_i)
      q_o <= IDLE;
    else
      q_o <= (sel_i & raw_i) | (~sel_i & IDLE);
  end
endmodule

// [pfm_periph_model.sv]
// peripheral side: output levels of timers, serial units, bus control
`timescale 1ns/1ns
module pfm_periph_model (
  // clock
  input wire logic clk_i,
  // levels requested by the bench
  input wire logic [22:0] pat_i,
  // peripheral output levels
  output logic [22:0] po_o
);
  // levels move just after the edge, as from real peripheral flops
  always_ff @(posedge clk_i)
    po_o <= pat_i;
endmodule

// [pfm_pin_mux.v]
// top: apb registers and pin function routing for ports 9, CM, CT
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "pfm_defines.vh"
module pfm_pin_mux (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // port 9 pads
  input wire [15:0] p9_pad_i,
  output wire [15:0] p9_pad_o,
  output wire [15:0] p9_pad_oe_o,
  // port CM pads
  input wire [3:0] cm_pad_i,
  output wire [3:0] cm_pad_o,
  output wire [3:0] cm_pad_oe_o,
  // port CT pads
  input wire [7:0] ct_pad_i,
  output wire [7:0] ct_pad_o,
  output wire [7:0] ct_pad_oe_o,
  // timer outputs from the timers
  input wire timer4_out_ch1_i,
  input wire timer4_out_ch0_i,
  input wire timer3_out_ch1_i,
  input wire timer3_out_ch0_i,
  input wire timer2_out_ch1_i,
  input wire timer2_out_ch0_i,
  input wire timer5_out_ch1_i,
  input wire timer5_out_ch0_i,
  // serial outputs from the serial units
  input wire serial_a4_transmit_i,
  input wire serial_a5_transmit_i,
  input wire serial_c0_transmit_i,
  input wire clocked_serial_b1_data_out_i,
  input wire clocked_serial_b1_clock_i,
  input wire clocked_serial_b1_clock_oe_i,
  input wire clocked_serial_b3_data_out_i,
  input wire clocked_serial_b3_clock_i,
  input wire clocked_serial_b3_clock_oe_i,
  // external bus outputs from the bus controller
  input wire clock_output_i,
  input wire bus_hold_acknowledge_i,
  input wire lower_byte_write_strobe_i,
  input wire upper_byte_write_strobe_i,
  input wire read_strobe_i,
  input wire address_strobe_i,
  // timer capture inputs to the timers
  output wire timer4_capture_in_ch1_o,
  output wire timer4_capture_in_ch0_o,
  output wire timer3_capture_in_ch1_o,
  output wire timer3_capture_in_ch0_o,
  output wire timer2_capture_in_ch1_o,
  output wire timer2_capture_in_ch0_o,
  output wire timer5_capture_in_ch1_o,
  output wire timer5_capture_in_ch0_o,
  // serial inputs to the serial units
  output wire serial_a4_receive_o,
  output wire serial_a5_receive_o,
  output wire serial_c0_receive_o,
  output wire clocked_serial_b1_data_in_o,
  output wire clocked_serial_b1_clock_o,
  output wire clocked_serial_b3_data_in_o,
  output wire clocked_serial_b3_clock_o,
  // interrupt and bus inputs
  output wire ext_interrupt_in4_o,
  output wire ext_interrupt_in5_o,
  output wire ext_interrupt_in6_o,
  output wire bus_wait_o,
  output wire bus_hold_request_o
);

  // per-pin mode, select and port registers
  reg [15:0] p9_lat_q;
  reg [15:0] p9_dir_q;
  reg [15:0] p9_alt_q;
  reg [15:0] p9_fsl_q;
  reg [15:0] p9_fsh_q;
  reg [3:0] cm_lat_q;
  reg [3:0] cm_dir_q;
  reg [3:0] cm_alt_q;
  reg [7:0] ct_lat_q;
  reg [7:0] ct_dir_q;
  reg [7:0] ct_alt_q;

  // apb answer path
  reg [31:0] rdata_d;
  reg hit_d;
  wire access_w;
  wire write_w;

  // routing
  wire [15:0] a_lo;
  wire [15:0] a_hi;
  wire [15:0] a_bb;
  reg [15:0] p9_ao_d;
  reg [15:0] p9_aoe_d;
  wire [3:0] cm_ao;
  wire [3:0] cm_aoe;
  wire [7:0] ct_ao;
  wire [7:0] ct_aoe;
  wire [`PFM_IN_W-1:0] in_sel;
  wire [`PFM_IN_W-1:0] in_raw;
  wire [`PFM_IN_W-1:0] in_q;

  // read-back
  wire [15:0] p9_rd;
  wire [3:0] cm_rd;
  wire [7:0] ct_rd;

  // per-pin active map for one {high, low} code
  function [15:0] sel_vec;
    input [15:0] alt;
    input [15:0] fsh;
    input [15:0] fsl;
    input [1:0] code;
    begin
      sel_vec = alt & (code[1] ? fsh : ~fsh) & (code[0] ? fsl : ~fsl);
    end
  endfunction

  // ---- apb slave: one wait state, answer registered ----
  assign access_w = psel_i & penable_i;
  assign write_w = access_w & pwrite_i & pready_o;

  always @*
  begin
    rdata_d = 32'h00000000;
    hit_d = 1'b1;
    case (paddr_i)
      `PFM_P9_DATA: rdata_d = {16'h0000, p9_rd};
      `PFM_P9_DIR: rdata_d = {16'h0000, p9_dir_q};
      `PFM_P9_ALT: rdata_d = {16'h0000, p9_alt_q};
      `PFM_P9_FSL: rdata_d = {16'h0000, p9_fsl_q};
      `PFM_P9_FSH: rdata_d = {16'h0000, p9_fsh_q};
      `PFM_CM_DATA: rdata_d = {28'h0000000, cm_rd};
      `PFM_CM_DIR: rdata_d = {28'h0000000, cm_dir_q};
      `PFM_CM_ALT: rdata_d = {28'h0000000, cm_alt_q};
      `PFM_CT_DATA: rdata_d = {24'h000000, ct_rd};
      `PFM_CT_DIR: rdata_d = {24'h000000, ct_dir_q};
      `PFM_CT_ALT: rdata_d = {24'h000000, ct_alt_q};
      default: hit_d = 1'b0;
    endcase
  end

  // pready rises in the second access cycle, then drops for one cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
    else
    begin
      pready_o <= access_w & ~pready_o;
      if (access_w && !pready_o)
      begin
        pslverr_o <= ~hit_d;
        prdata_o <= pwrite_i ? 32'h00000000 : rdata_d;
      end
      else
      begin
        pslverr_o <= 1'b0;
        prdata_o <= 32'h00000000;
      end
    end
  end

  // register writes land on the completing edge only
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p9_lat_q <= `PFM_RST_LAT16;
      p9_dir_q <= `PFM_RST_DIR16;
      p9_alt_q <= `PFM_RST_ALT16;
      p9_fsl_q <= `PFM_RST_FS16;
      p9_fsh_q <= `PFM_RST_FS16;
      cm_lat_q <= `PFM_RST_LAT4;
      cm_dir_q <= `PFM_RST_DIR4;
      cm_alt_q <= `PFM_RST_ALT4;
      ct_lat_q <= `PFM_RST_LAT8;
      ct_dir_q <= `PFM_RST_DIR8;
      ct_alt_q <= `PFM_RST_ALT8;
    end
    else if (write_w)
    begin
      case (paddr_i)
        `PFM_P9_DATA: p9_lat_q <= pwdata_i[15:0];
        `PFM_P9_DIR: p9_dir_q <= pwdata_i[15:0];
        `PFM_P9_ALT: p9_alt_q <= pwdata_i[15:0];
        `PFM_P9_FSL: p9_fsl_q <= pwdata_i[15:0];
        // bits without a high select stay zero so low alone decodes
        `PFM_P9_FSH: p9_fsh_q <= pwdata_i[15:0] & `PFM_P9_FSH_MASK;
        `PFM_CM_DATA: cm_lat_q <= pwdata_i[3:0];
        `PFM_CM_DIR: cm_dir_q <= pwdata_i[3:0];
        `PFM_CM_ALT: cm_alt_q <= pwdata_i[3:0];
        `PFM_CT_DATA: ct_lat_q <= pwdata_i[7:0];
        `PFM_CT_DIR: ct_dir_q <= pwdata_i[7:0];
        `PFM_CT_ALT: ct_alt_q <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // ---- function selection ----
  assign a_lo = sel_vec(p9_alt_q, p9_fsh_q, p9_fsl_q, `PFM_SEL_LO);
  assign a_hi = sel_vec(p9_alt_q, p9_fsh_q, p9_fsl_q, `PFM_SEL_HI);
  assign a_bb = sel_vec(p9_alt_q, p9_fsh_q, p9_fsl_q, `PFM_SEL_BOTH);

  // code 00 and pins 9.0/9.1 fall through to no drive
  always @*
  begin
    p9_ao_d = 16'h0000;
    p9_aoe_d = 16'h0000;
    // pin 2
    p9_ao_d[2] = (a_hi[2] & timer4_out_ch1_i)
      | (a_bb[2] & serial_a4_transmit_i);
    p9_aoe_d[2] = a_hi[2] | a_bb[2];
    // pin 3
    p9_ao_d[3] = a_hi[3] & timer4_out_ch0_i;
    p9_aoe_d[3] = a_hi[3];
    // pin 4
    p9_ao_d[4] = (a_hi[4] & timer3_out_ch1_i)
      | (a_bb[4] & serial_a5_transmit_i);
    p9_aoe_d[4] = a_hi[4] | a_bb[4];
    // pin 5
    p9_ao_d[5] = a_hi[5] & timer3_out_ch0_i;
    p9_aoe_d[5] = a_hi[5];
    // pin 6: transmit drives out despite the odd printed direction
    p9_ao_d[6] = (a_lo[6] & serial_c0_transmit_i)
      | (a_bb[6] & timer2_out_ch1_i);
    p9_aoe_d[6] = a_lo[6] | a_bb[6];
    // pin 7
    p9_ao_d[7] = a_bb[7] & timer2_out_ch0_i;
    p9_aoe_d[7] = a_bb[7];
    // pins 8, 9
    p9_ao_d[8] = a_lo[8] & clocked_serial_b1_data_out_i;
    p9_aoe_d[8] = a_lo[8];
    p9_ao_d[9] = a_lo[9] & clocked_serial_b1_clock_i;
    p9_aoe_d[9] = a_lo[9] & clocked_serial_b1_clock_oe_i;
    // pins 11, 12; 10 and 13 are inputs only
    p9_ao_d[11] = a_lo[11] & clocked_serial_b3_data_out_i;
    p9_aoe_d[11] = a_lo[11];
    p9_ao_d[12] = a_lo[12] & clocked_serial_b3_clock_i;
    p9_aoe_d[12] = a_lo[12] & clocked_serial_b3_clock_oe_i;
    // pins 14, 15
    p9_ao_d[14] = a_bb[14] & timer5_out_ch1_i;
    p9_aoe_d[14] = a_bb[14];
    p9_ao_d[15] = a_bb[15] & timer5_out_ch0_i;
    p9_aoe_d[15] = a_bb[15];
  end

  // CM: 0 wait in, 1 clock out, 2 hold ack out, 3 hold request in
  assign cm_ao = {1'b0, bus_hold_acknowledge_i, clock_output_i, 1'b0};
  assign cm_aoe = 4'h6;

  // CT: 0/1 write strobes, 4 read, 6 address strobe; rest no function
  assign ct_ao = {1'b0, address_strobe_i, 1'b0, read_strobe_i, 2'b00,
    upper_byte_write_strobe_i, lower_byte_write_strobe_i};
  assign ct_aoe = 8'h53;

  // both shared receivers see pin 9.7; software keeps one stopped
  assign in_sel = {cm_alt_q[3], cm_alt_q[0], a_hi[15], a_hi[14],
    a_lo[15], a_lo[14], a_lo[13], a_lo[12], a_lo[10], a_lo[9],
    a_lo[7], a_lo[7], a_hi[7], a_hi[6], a_bb[5], a_lo[5], a_lo[4],
    a_bb[3], a_lo[3], a_lo[2]};
  assign in_raw = {cm_pad_i[3], cm_pad_i[0], p9_pad_i[15], p9_pad_i[14],
    p9_pad_i[15], p9_pad_i[14], p9_pad_i[13], p9_pad_i[12],
    p9_pad_i[10], p9_pad_i[9], p9_pad_i[7], p9_pad_i[7], p9_pad_i[7],
    p9_pad_i[6], p9_pad_i[5], p9_pad_i[5], p9_pad_i[4], p9_pad_i[3],
    p9_pad_i[3], p9_pad_i[2]};

  pfm_in_stage #(
    .N(`PFM_IN_W),
    .IDLE(`PFM_IN_IDLE)
  ) u_in (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(in_sel),
    .raw_i(in_raw),
    .q_o(in_q)
  );

  assign timer4_capture_in_ch1_o = in_q[0];
  assign timer4_capture_in_ch0_o = in_q[1];
  assign serial_a4_receive_o = in_q[2];
  assign timer3_capture_in_ch1_o = in_q[3];
  assign timer3_capture_in_ch0_o = in_q[4];
  assign serial_a5_receive_o = in_q[5];
  assign timer2_capture_in_ch1_o = in_q[6];
  assign timer2_capture_in_ch0_o = in_q[7];
  assign clocked_serial_b1_data_in_o = in_q[8];
  assign serial_c0_receive_o = in_q[9];
  assign clocked_serial_b1_clock_o = in_q[10];
  assign clocked_serial_b3_data_in_o = in_q[11];
  assign clocked_serial_b3_clock_o = in_q[12];
  assign ext_interrupt_in4_o = in_q[13];
  assign ext_interrupt_in5_o = in_q[14];
  assign ext_interrupt_in6_o = in_q[15];
  assign timer5_capture_in_ch1_o = in_q[16];
  assign timer5_capture_in_ch0_o = in_q[17];
  assign bus_wait_o = in_q[18];
  assign bus_hold_request_o = in_q[19];

  // ---- pad drivers ----
  pfm_port_cell #(
    .W(16)
  ) u_p9 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lat_i(p9_lat_q),
    .dir_i(p9_dir_q),
    .alt_i(p9_alt_q),
    .alt_out_i(p9_ao_d),
    .alt_oe_i(p9_aoe_d),
    .pad_i(p9_pad_i),
    .pad_o(p9_pad_o),
    .pad_oe_o(p9_pad_oe_o),
    .rd_o(p9_rd)
  );

  pfm_port_cell #(
    .W(4)
  ) u_cm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lat_i(cm_lat_q),
    .dir_i(cm_dir_q),
    .alt_i(cm_alt_q),
    .alt_out_i(cm_ao),
    .alt_oe_i(cm_aoe),
    .pad_i(cm_pad_i),
    .pad_o(cm_pad_o),
    .pad_oe_o(cm_pad_oe_o),
    .rd_o(cm_rd)
  );

  pfm_port_cell #(
    .W(8)
  ) u_ct (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lat_i(ct_lat_q),
    .dir_i(ct_dir_q),
    .alt_i(ct_alt_q),
    .alt_out_i(ct_ao),
    .alt_oe_i(ct_aoe),
    .pad_i(ct_pad_i),
    .pad_o(ct_pad_o),
    .pad_oe_o(ct_pad_oe_o),
    .rd_o(ct_rd)
  );
endmodule

// [pfm_pin_mux_props.sv]
// port-level assertions for the pin function multiplexer
`timescale 1ns/1ns
`include "pfm_defines.vh"
module pfm_pin_mux_props (
  // clock and reset
  input logic clk_i,
  input logic rst_i,
  // apb
  input logic psel_i,
  input logic penable_i,
  input logic pwrite_i,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic pready_o,
  // pads
  input logic [15:0] p9_pad_i,
  input logic [15:0] p9_pad_o,
  input logic [15:0] p9_pad_oe_o,
  input logic [7:0] ct_pad_o,
  input logic [7:0] ct_pad_oe_o,
  // peripherals
  input logic serial_a4_transmit_i,
  input logic serial_c0_transmit_i,
  input logic clocked_serial_b1_data_out_i,
  input logic lower_byte_write_strobe_i,
  input logic timer4_capture_in_ch1_o,
  input logic serial_a5_receive_o,
  input logic serial_c0_receive_o,
  input logic clocked_serial_b1_data_in_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] lat_q, dir_q, alt_q, fsl_q, fsh_q;
  wire wr = psel_i & penable_i & pready_o & pwrite_i;
  // shadow of the port 9 registers, taken from completed writes
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      lat_q <= `PFM_RST_LAT16;
      dir_q <= `PFM_RST_DIR16;
      alt_q <= `PFM_RST_ALT16;
      fsl_q <= `PFM_RST_FS16;
      fsh_q <= `PFM_RST_FS16;
    end
    else if (wr)
    begin
      if (paddr_i == `PFM_P9_DATA)
        lat_q <= pwdata_i[15:0];
      if (paddr_i == `PFM_P9_DIR)
        dir_q <= pwdata_i[15:0];
      if (paddr_i == `PFM_P9_ALT)
        alt_q <= pwdata_i[15:0];
      if (paddr_i == `PFM_P9_FSL)
        fsl_q <= pwdata_i[15:0];
      if (paddr_i == `PFM_P9_FSH)
        fsh_q <= pwdata_i[15:0] & `PFM_P9_FSH_MASK;
    end
  sequence s_rd_data;
    psel_i && penable_i && pready_o && !pwrite_i && paddr_i == `PFM_P9_DATA;
  endsequence
  sequence s_ct_alt_on;
    wr && paddr_i == `PFM_CT_ALT && pwdata_i[0];
  endsequence
  property p_a4_tx;
    $past(alt_q[2] & fsh_q[2] & fsl_q[2]) |->
      p9_pad_oe_o[2] && p9_pad_o[2] == $past(serial_a4_transmit_i);
  endproperty
  a_a4_tx: assert property (p_a4_tx) else $error("9.2 not a4 tx");
  property p_a5_rx;
    $past(alt_q[5] & fsh_q[5] & fsl_q[5]) |->
      !p9_pad_oe_o[5] && serial_a5_receive_o == $past(p9_pad_i[5]);
  endproperty
  a_a5_rx: assert property (p_a5_rx) else $error("9.5 not a5 rx");
  property p_c0_tx;
    $past(alt_q[6] & !fsh_q[6] & fsl_q[6]) |->
      p9_pad_oe_o[6] && p9_pad_o[6] == $past(serial_c0_transmit_i);
  endproperty
  a_c0_tx: assert property (p_c0_tx) else $error("9.6 not c0 tx");
  property p_shared;
    $past(alt_q[7] & !fsh_q[7] & fsl_q[7]) |->
      serial_c0_receive_o == $past(p9_pad_i[7]) &&
      clocked_serial_b1_data_in_o == $past(p9_pad_i[7]);
  endproperty
  a_shared: assert property (p_shared) else $error("9.7 not shared");
  property p_b1_out;
    $past(alt_q[8] & fsl_q[8]) |->
      p9_pad_oe_o[8] && p9_pad_o[8] == $past(clocked_serial_b1_data_out_i);
  endproperty
  a_b1_out: assert property (p_b1_out) else $error("9.8 not b1 out");
  property p_ct_wr;
    s_ct_alt_on |->
      ##2 ct_pad_oe_o[0] && ct_pad_o[0] == $past(lower_byte_write_strobe_i);
  endproperty
  a_ct_wr: assert property (p_ct_wr) else $error("ct0 not strobe");
  property p_unlisted;
    $past(alt_q[2] & !fsh_q[2] & !fsl_q[2]) |->
      !p9_pad_oe_o[2] && !timer4_capture_in_ch1_o;
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("9.2 not idle");
  property p_port;
    !$past(alt_q[15]) |-> p9_pad_oe_o[15] == !$past(dir_q[15]) &&
      (!p9_pad_oe_o[15] || p9_pad_o[15] == $past(lat_q[15]));
  endproperty
  a_port: assert property (p_port) else $error("9.15 port mode");
  property p_read;
    s_rd_data |->
      prdata_o[15:0] == (($past(p9_pad_i) & dir_q) | (lat_q & ~dir_q));
  endproperty
  a_read: assert property (p_read) else $error("data read wrong");
endmodule
bind pfm_pin_mux pfm_pin_mux_props i_props (.*);

// [pfm_port_cell.v]
// per-port pad driver and data read-back
`timescale 1ns/1ns
module pfm_port_cell #(
  parameter W = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // port control
  input wire [W-1:0] lat_i,
  input wire [W-1:0] dir_i,
  input wire [W-1:0] alt_i,
  // peripheral drive
  input wire [W-1:0] alt_out_i,
  input wire [W-1:0] alt_oe_i,
  // pad
  input wire [W-1:0] pad_i,
  output reg [W-1:0] pad_o,
  output reg [W-1:0] pad_oe_o,
  // read-back
  output wire [W-1:0] rd_o
);
  // direction bit 1 means input, so port mode drives when it is 0
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_o <= {W{1'b0}};
      pad_oe_o <= {W{1'b0}};
    end
    else
    begin
      pad_o <= (alt_i & alt_out_i) | (~alt_i & lat_i);
      pad_oe_o <= (alt_i & alt_oe_i) | (~alt_i & ~dir_i);
    end
  end

  // same in both modes
  assign rd_o = (dir_i & pad_i) | (~dir_i & lat_i);
endmodule

// [tb_port9_cm_ct_alt_function_mux.sv]
// bench for the port 9 / CM / CT pin function multiplexer
`timescale 1ns/1ns
`include "pfm_defines.vh"
`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED at %0t: got %h want %h", $time, (a), (e)); \
    end \
  end
module tb_port9_cm_ct_alt_function_mux;
  logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd;
  logic er;
  logic [27:0] pad = 0;
  logic [22:0] pat = 0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o;
  wire [22:0] po;
  wire [19:0] pi;
  wire [15:0] p9_pad_o, p9_pad_oe_o;
  wire [3:0] cm_pad_o, cm_pad_oe_o;
  wire [7:0] ct_pad_o, ct_pad_oe_o;
  wire [27:0] dout = {ct_pad_o, cm_pad_o, p9_pad_o};
  wire [27:0] doe = {ct_pad_oe_o, cm_pad_oe_o, p9_pad_oe_o};
  int fail_count = 0, num_checks = 0;
  pfm_periph_model i_periph (.clk_i(clk_i), .pat_i(pat), .po_o(po));
  pfm_pin_mux i_dut (.*, .p9_pad_i(pad[15:0]), .cm_pad_i(pad[19:16]),
    .ct_pad_i(pad[27:20]), .timer4_out_ch1_i(po[0]),
    .timer4_out_ch0_i(po[1]), .timer3_out_ch1_i(po[2]),
    .timer3_out_ch0_i(po[3]), .timer2_out_ch1_i(po[4]),
    .timer2_out_ch0_i(po[5]), .timer5_out_ch1_i(po[6]),
    .timer5_out_ch0_i(po[7]), .serial_a4_transmit_i(po[8]),
    .serial_a5_transmit_i(po[9]), .serial_c0_transmit_i(po[10]),
    .clocked_serial_b1_data_out_i(po[11]),
    .clocked_serial_b1_clock_i(po[12]), .clocked_serial_b1_clock_oe_i(po[13]),
    .clocked_serial_b3_data_out_i(po[14]),
    .clocked_serial_b3_clock_i(po[15]), .clocked_serial_b3_clock_oe_i(po[16]),
    .clock_output_i(po[17]), .bus_hold_acknowledge_i(po[18]),
    .lower_byte_write_strobe_i(po[19]), .upper_byte_write_strobe_i(po[20]),
    .read_strobe_i(po[21]), .address_strobe_i(po[22]),
    .timer4_capture_in_ch1_o(pi[0]), .timer4_capture_in_ch0_o(pi[1]),
    .timer3_capture_in_ch1_o(pi[2]), .timer3_capture_in_ch0_o(pi[3]),
    .timer2_capture_in_ch1_o(pi[4]), .timer2_capture_in_ch0_o(pi[5]),
    .timer5_capture_in_ch1_o(pi[6]), .timer5_capture_in_ch0_o(pi[7]),
    .serial_a4_receive_o(pi[8]), .serial_a5_receive_o(pi[9]),
    .serial_c0_receive_o(pi[10]), .clocked_serial_b1_data_in_o(pi[11]),
    .clocked_serial_b1_clock_o(pi[12]), .clocked_serial_b3_data_in_o(pi[13]),
    .clocked_serial_b3_clock_o(pi[14]), .ext_interrupt_in4_o(pi[15]),
    .ext_interrupt_in5_o(pi[16]), .ext_interrupt_in6_o(pi[17]),
    .bus_wait_o(pi[18]), .bus_hold_request_o(pi[19]));
  initial
    forever #2 clk_i = ~clk_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic apb(input bit w, input [11:0] a, input [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // latch 1 and direction output everywhere, so a leak of port mode shows
  task automatic route(input int port, pin, input [1:0] code,
    input bit out, input int idx);
    logic [11:0] b;
    int g;
    bit ck;
    b = port == 0 ? `PFM_P9_DATA : port == 1 ? `PFM_CM_DATA : `PFM_CT_DATA;
    g = pin + (port == 1 ? 16 : port == 2 ? 20 : 0);
    ck = out && (idx == 12 || idx == 15);
    apb(1, b, 32'hffff);
    apb(1, b + 12'h004, 32'h0);
    if (port == 0)
    begin
      apb(1, `PFM_P9_FSL, {31'h0, code[0]} << pin);
      apb(1, `PFM_P9_FSH, {31'h0, code[1]} << pin);
    end
    apb(1, b + 12'h008, 32'h1 << pin);
    if (out)
    begin
      pat <= (23'h1 << idx) | (ck ? 23'h1 << (idx + 1) : 23'h0);
      tick(3);
      `CHK(doe[g], 1'b1)
      `CHK(dout[g], 1'b1)
      pat <= ~pat;
      tick(3);
      `CHK(doe[g], !ck)
      if (!ck)
        `CHK(dout[g], 1'b0)
      // the shared clock pin also feeds the unit's clock input
      if (ck)
      begin
        pad <= 28'h1 << g;
        tick(3);
        `CHK(pi[idx == 12 ? 12 : 14], 1'b1)
        pad <= 28'h0;
        tick(3);
        `CHK(pi[idx == 12 ? 12 : 14], 1'b0)
      end
    end
    else
    begin
      pad <= 28'h1 << g;
      tick(3);
      `CHK(doe[g], 1'b0)
      `CHK(pi[idx], 1'b1)
      pad <= ~(28'h1 << g);
      tick(3);
      `CHK(pi[idx], 1'b0)
    end
  endtask
  task results;
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    results;
  end
  initial
  begin
    tick(3);
    rst_i <= 1'b0;
    apb(0, `PFM_P9_DIR, 0);
    `CHK(rd, {16'h0, `PFM_RST_DIR16})
    apb(0, `PFM_P9_ALT, 0);
    `CHK(rd, {16'h0, `PFM_RST_ALT16})
    apb(0, `PFM_CT_DIR, 0);
    `CHK(rd, {24'h0, `PFM_RST_DIR8})
    `CHK(doe, 28'h0)
    `CHK(pi, 20'h07f00)
    apb(0, 12'h0fc, 0);
    `CHK({er, rd}, 33'h100000000)
    apb(1, `PFM_P9_FSH, 32'hffff);
    apb(0, `PFM_P9_FSH, 0);
    `CHK(rd, {16'h0, `PFM_P9_FSH_MASK})
    pad <= 28'h3c5a;
    apb(1, `PFM_P9_DATA, 32'ha5c3);
    apb(1, `PFM_P9_DIR, 32'h00ff);
    tick(2);
    `CHK(doe[15:0], 16'hff00)
    `CHK(dout[15:8], 8'ha5)
    apb(0, `PFM_P9_DATA, 0);
    `CHK(rd, 32'ha55a)
    apb(1, `PFM_P9_ALT, 32'hffff);
    apb(0, `PFM_P9_DATA, 0);
    `CHK(rd, 32'ha55a)
    apb(1, `PFM_P9_FSH, 0);
    apb(1, `PFM_P9_FSL, 32'h2);
    apb(1, `PFM_P9_ALT, 32'h6);
    apb(1, `PFM_CT_ALT, 32'h4);
    pad <= 28'hfffffff;
    tick(3);
    `CHK(doe[1], 1'b0)
    `CHK(doe[2], 1'b0)
    `CHK(pi[0], 1'b0)
    `CHK(doe[22], 1'b0)
    route(0, 2, 1, 0, 0);
    route(0, 2, 2, 1, 0);
    route(0, 2, 3, 1, 8);
    route(0, 3, 1, 0, 1);
    route(0, 3, 2, 1, 1);
    route(0, 3, 3, 0, 8);
    route(0, 4, 1, 0, 2);
    route(0, 4, 2, 1, 2);
    route(0, 4, 3, 1, 9);
    route(0, 5, 1, 0, 3);
    route(0, 5, 2, 1, 3);
    route(0, 5, 3, 0, 9);
    route(0, 6, 1, 1, 10);
    route(0, 6, 2, 0, 4);
    route(0, 6, 3, 1, 4);
    route(0, 7, 1, 0, 11);
    route(0, 7, 1, 0, 10);
    route(0, 7, 2, 0, 5);
    route(0, 7, 3, 1, 5);
    route(0, 8, 1, 1, 11);
    route(0, 9, 1, 1, 12);
    route(0, 10, 1, 0, 13);
    route(0, 11, 1, 1, 14);
    route(0, 12, 1, 1, 15);
    route(0, 13, 1, 0, 15);
    route(0, 14, 1, 0, 16);
    route(0, 14, 2, 0, 6);
    route(0, 14, 3, 1, 6);
    route(0, 15, 1, 0, 17);
    route(0, 15, 2, 0, 7);
    route(0, 15, 3, 1, 7);
    route(1, 0, 0, 0, 18);
    route(1, 1, 0, 1, 17);
    route(1, 2, 0, 1, 18);
    route(1, 3, 0, 0, 19);
    route(2, 0, 0, 1, 19);
    route(2, 1, 0, 1, 20);
    route(2, 4, 0, 1, 21);
    route(2, 6, 0, 1, 22);
    results;
  end
endmodule
